/* File: arh_consts.svh */
// Register offsets, field positions, reset values and sizes of the result holding registers.
`ifndef ARH_CONSTS_SVH
`define ARH_CONSTS_SVH

`define ARH_OFS_SLOT_C     8'h00
`define ARH_OFS_SLOT_D     8'h04
`define ARH_OFS_SLOT_E     8'h08
`define ARH_OFS_SLOT_F     8'h0c
`define ARH_OFS_IRQ_STATUS 8'h10
`define ARH_OFS_IRQ_MASK   8'h14
`define ARH_ADR_W          8
`define ARH_RES_W          10
`define ARH_RES_LSB        6
`define ARH_RES_MSB        15
`define ARH_OVR_BIT        1
`define ARH_HELD_BIT       0
`define ARH_NUM_SLOTS      4
`define ARH_RST_WORD       32'h0000_0000
`define ARH_IRQ_OVR_LSB    4

`endif

/* File: arh_pkg.sv */
// Types shared by the result holding register block.
package arh_pkg;
    typedef struct packed {
        logic [9:0] value;
        logic       overwrite;
        logic       held;
    } arh_slot_s;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } arh_wb_req_s;
endpackage

/* File: arh_result_regs.sv */
// Conversion result holding registers with a classic Wishbone slave and interrupt.
`timescale 1ns/1ps
`include "arh_consts.svh"
module arh_result_regs #(
    parameter int RES_W     = `ARH_RES_W,
    parameter int NUM_SLOTS = `ARH_NUM_SLOTS
) (
    // Clock and reset.
    input  wire logic                     clk_in,
    input  wire logic                     rst_b_in,
    // Wishbone slave.
    input  wire logic                     wb_cyc_in,
    input  wire logic                     wb_stb_in,
    input  wire logic                     wb_we_in,
    input  wire logic [3:0]               wb_sel_in,
    input  wire logic [`ARH_ADR_W-1:0]    wb_adr_in,
    input  wire logic [31:0]              wb_dat_in,
    output logic [31:0]                   wb_dat_out,
    output logic                          wb_ack_out,
    // Converter core write port.
    input  wire logic                     conv_wr_in,
    input  wire logic [1:0]               conv_slot_in,
    input  wire logic [RES_W-1:0]         conv_value_in,
    // Interrupt.
    output logic                          irq_out
);
    if (RES_W != `ARH_RES_W || NUM_SLOTS != `ARH_NUM_SLOTS)
    begin : g_bad_params
        $error("Result width and slot count are fixed by the register layout.");
    end

    typedef struct packed {
        logic [31:0]          dat;
        logic                 ack;
        logic                 irq;
        logic [2*NUM_SLOTS-1:0] status;
        logic [2*NUM_SLOTS-1:0] mask;
    } arh_top_state_s;

    arh_top_state_s state_ff;
    arh_top_state_s nxt_state;

    arh_pkg::arh_wb_req_s req;
    logic [RES_W-1:0]     slot_value [NUM_SLOTS];
    logic [NUM_SLOTS-1:0] slot_held;
    logic [NUM_SLOTS-1:0] slot_ovr;
    logic [NUM_SLOTS-1:0] slot_wr;
    logic [NUM_SLOTS-1:0] slot_rd;
    logic                 access;
    logic                 rd_access;
    logic                 wr_access;
    logic [2*NUM_SLOTS-1:0] status_set;
    logic [2*NUM_SLOTS-1:0] status_clr;
    logic [2*NUM_SLOTS-1:0] wr_bits;

    assign req = '{cyc: wb_cyc_in, stb: wb_stb_in, we: wb_we_in,
                   sel: wb_sel_in, adr: wb_adr_in, dat: wb_dat_in};

    // Each access is answered in the cycle after it is seen; ack falls next cycle.
    assign access    = req.cyc && req.stb && !state_ff.ack;
    assign rd_access = access && !req.we;
    assign wr_access = access && req.we;
    assign wr_bits   = req.dat[2*NUM_SLOTS-1:0];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SLOTS; gi++)
        begin : g_slot
            // A read with no byte lane selected still counts as a read of the slot.
            assign slot_rd[gi] = rd_access &&
                (req.adr == `ARH_OFS_SLOT_C + 8'(4 * gi));
            assign slot_wr[gi] = conv_wr_in && (conv_slot_in == 2'(gi));
            arh_slot #(
                .RES_W (RES_W)
            ) u_slot (
                .clk_in    (clk_in),
                .rst_b_in  (rst_b_in),
                .wr_in     (slot_wr[gi]),
                .value_in  (conv_value_in),
                .rd_in     (slot_rd[gi]),
                .value_out (slot_value[gi]),
                .held_out  (slot_held[gi]),
                .ovr_out   (slot_ovr[gi])
            );
            assign status_set[gi]             = slot_wr[gi];
            assign status_set[gi + NUM_SLOTS] = slot_wr[gi] && slot_held[gi] && !slot_rd[gi];
        end
    endgenerate

    assign status_clr = (wr_access && req.adr == `ARH_OFS_IRQ_STATUS && req.sel[0])
                        ? wr_bits : '0;

    always_comb
    begin
        nxt_state     = state_ff;
        nxt_state.ack = access;
        nxt_state.dat = `ARH_RST_WORD;
        // Hardware events win over a software clear in the same cycle.
        nxt_state.status = (state_ff.status & ~status_clr) | status_set;
        if (wr_access && req.adr == `ARH_OFS_IRQ_MASK && req.sel[0])
        begin
            nxt_state.mask = wr_bits;
        end
        if (rd_access)
        begin
            unique case (req.adr)
                `ARH_OFS_SLOT_C, `ARH_OFS_SLOT_D, `ARH_OFS_SLOT_E, `ARH_OFS_SLOT_F:
                begin
                    // Writes to slot registers are acknowledged and ignored.
                    nxt_state.dat[`ARH_RES_MSB:`ARH_RES_LSB] = slot_value[req.adr[3:2]];
                    nxt_state.dat[`ARH_OVR_BIT]  = slot_ovr[req.adr[3:2]];
                    nxt_state.dat[`ARH_HELD_BIT] = slot_held[req.adr[3:2]];
                end
                `ARH_OFS_IRQ_STATUS:
                begin
                    nxt_state.dat[2*NUM_SLOTS-1:0] = state_ff.status;
                end
                `ARH_OFS_IRQ_MASK:
                begin
                    nxt_state.dat[2*NUM_SLOTS-1:0] = state_ff.mask;
                end
                default:
                begin
                    nxt_state.dat = `ARH_RST_WORD;
                end
            endcase
        end
        nxt_state.irq = |(nxt_state.status & nxt_state.mask);
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign wb_dat_out = state_ff.dat;
    assign wb_ack_out = state_ff.ack;
    assign irq_out    = state_ff.irq;

    sequence s_slot_read;
        wb_cyc_in && wb_stb_in && !wb_we_in && !wb_ack_out &&
        wb_adr_in == `ARH_OFS_SLOT_C && !conv_wr_in;
    endsequence

    property p_unused_zero;
        @(posedge clk_in) disable iff (!rst_b_in)
        s_slot_read |=> wb_ack_out && wb_dat_out[31:16] == 16'h0000 &&
                         wb_dat_out[5:2] == 4'h0;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("Unused bits of a result register read nonzero.");

    property p_read_flags;
        @(posedge clk_in) disable iff (!rst_b_in)
        s_slot_read |=> !slot_held[0] && !slot_ovr[0];
    endproperty
    a_read_flags: assert property (p_read_flags)
        else $error("Read of a result register left its flags set.");

    property p_ack_one_cycle;
        @(posedge clk_in) disable iff (!rst_b_in)
        wb_ack_out |=> !wb_ack_out;
    endproperty
    a_ack_one_cycle: assert property (p_ack_one_cycle)
        else $error("Acknowledge held longer than one cycle.");

    property p_irq_level;
        @(posedge clk_in) disable iff (!rst_b_in)
        $changed(irq_out) |-> $past(conv_wr_in) || $past(wr_access);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("Interrupt changed without a result or a register write.");

    sequence s_take;
        wb_cyc_in && wb_stb_in && !wb_ack_out;
    endsequence

    sequence s_mask_write;
        wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out && wb_sel_in[0] &&
        wb_adr_in == `ARH_OFS_IRQ_MASK;
    endsequence

    sequence s_status_write;
        wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out && wb_sel_in[0] &&
        wb_adr_in == `ARH_OFS_IRQ_STATUS;
    endsequence

    sequence s_slot_c_write;
        wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out &&
        wb_adr_in == `ARH_OFS_SLOT_C && !conv_wr_in;
    endsequence

    property p_ack_after_take;
        @(posedge clk_in) disable iff (!rst_b_in)
        s_take |=> wb_ack_out;
    endproperty
    a_ack_after_take: assert property (p_ack_after_take)
        else $error("Bus access was not acknowledged in the next cycle.");

    property p_no_ack_idle;
        @(posedge clk_in) disable iff (!rst_b_in)
        !(wb_cyc_in && wb_stb_in) |=> !wb_ack_out;
    endproperty
    a_no_ack_idle: assert property (p_no_ack_idle)
        else $error("Acknowledge given without a bus request.");

    property p_dat_idle_zero;
        @(posedge clk_in) disable iff (!rst_b_in)
        !wb_ack_out |-> wb_dat_out == `ARH_RST_WORD;
    endproperty
    a_dat_idle_zero: assert property (p_dat_idle_zero)
        else $error("Read data nonzero outside an acknowledge.");

    property p_high_half_zero;
        @(posedge clk_in) disable iff (!rst_b_in)
        wb_ack_out |-> wb_dat_out[31:16] == 16'h0000;
    endproperty
    a_high_half_zero: assert property (p_high_half_zero)
        else $error("Upper half of a register read nonzero.");

    property p_value_reads_back;
        @(posedge clk_in) disable iff (!rst_b_in)
        s_slot_read |=> wb_dat_out[`ARH_RES_MSB:`ARH_RES_LSB] == $past(slot_value[0]);
    endproperty
    a_value_reads_back: assert property (p_value_reads_back)
        else $error("Read result field differs from the stored result.");

    property p_held_reads_back;
        @(posedge clk_in) disable iff (!rst_b_in)
        s_slot_read |=> wb_dat_out[`ARH_HELD_BIT] == $past(slot_held[0]);
    endproperty
    a_held_reads_back: assert property (p_held_reads_back)
        else $error("Read held flag differs from the slot state.");

    property p_ovr_reads_back;
        @(posedge clk_in) disable iff (!rst_b_in)
        s_slot_read |=> wb_dat_out[`ARH_OVR_BIT] == $past(slot_ovr[0]);
    endproperty
    a_ovr_reads_back: assert property (p_ovr_reads_back)
        else $error("Read overwrite flag differs from the slot state.");

    property p_slot_write_ignored;
        @(posedge clk_in) disable iff (!rst_b_in)
        s_slot_c_write |=> $stable(slot_value[0]) && $stable(slot_held[0]) &&
                           $stable(slot_ovr[0]);
    endproperty
    a_slot_write_ignored: assert property (p_slot_write_ignored)
        else $error("Bus write changed a result slot.");

    property p_new_result_status;
        @(posedge clk_in) disable iff (!rst_b_in)
        conv_wr_in |=> state_ff.status[$past(conv_slot_in)];
    endproperty
    a_new_result_status: assert property (p_new_result_status)
        else $error("New result did not set its status bit.");

    property p_overwrite_status;
        @(posedge clk_in) disable iff (!rst_b_in)
        conv_wr_in && slot_held[conv_slot_in] && !slot_rd[conv_slot_in]
            |=> state_ff.status[NUM_SLOTS + $past(conv_slot_in)];
    endproperty
    a_overwrite_status: assert property (p_overwrite_status)
        else $error("Overwrite did not set its status bit.");

    property p_mask_write;
        @(posedge clk_in) disable iff (!rst_b_in)
        s_mask_write |=> state_ff.mask == $past(wb_dat_in[2*NUM_SLOTS-1:0]);
    endproperty
    a_mask_write: assert property (p_mask_write)
        else $error("Mask write did not land.");

    property p_mask_hold;
        @(posedge clk_in) disable iff (!rst_b_in)
        !wb_we_in |=> $stable(state_ff.mask);
    endproperty
    a_mask_hold: assert property (p_mask_hold)
        else $error("Mask changed without a write.");

    property p_status_clear;
        @(posedge clk_in) disable iff (!rst_b_in)
        s_status_write ##0 !conv_wr_in
            |=> (state_ff.status & $past(wb_dat_in[2*NUM_SLOTS-1:0])) == '0;
    endproperty
    a_status_clear: assert property (p_status_clear)
        else $error("Writing ones did not clear status bits.");

    // A new result must never be lost to a clear landing in the same cycle.
    property p_set_beats_clear;
        @(posedge clk_in) disable iff (!rst_b_in)
        s_status_write ##0 conv_wr_in |=> state_ff.status[$past(conv_slot_in)];
    endproperty
    a_set_beats_clear: assert property (p_set_beats_clear)
        else $error("Software clear beat a new result.");

    property p_no_mask_no_irq;
        @(posedge clk_in) disable iff (!rst_b_in)
        state_ff.mask == '0 |-> !irq_out;
    endproperty
    a_no_mask_no_irq: assert property (p_no_mask_no_irq)
        else $error("Interrupt raised with every source masked.");

    property p_unmapped_zero;
        @(posedge clk_in) disable iff (!rst_b_in)
        wb_cyc_in && wb_stb_in && !wb_we_in && !wb_ack_out &&
            wb_adr_in > `ARH_OFS_IRQ_MASK |=> wb_dat_out == `ARH_RST_WORD;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero)
        else $error("Unmapped address read nonzero.");

    property p_status_reads_back;
        @(posedge clk_in) disable iff (!rst_b_in)
        wb_cyc_in && wb_stb_in && !wb_we_in && !wb_ack_out && wb_adr_in == `ARH_OFS_IRQ_STATUS
            |=> wb_dat_out[2*NUM_SLOTS-1:0] == $past(state_ff.status);
    endproperty
    a_status_reads_back: assert property (p_status_reads_back)
        else $error("Status read differs from the status bits.");

    property p_held_needs_write;
        @(posedge clk_in) disable iff (!rst_b_in)
        !slot_held[0] && !(conv_wr_in && conv_slot_in == 2'h0) |=> !slot_held[0];
    endproperty
    a_held_needs_write: assert property (p_held_needs_write)
        else $error("Held flag set without a stored result.");

    // A read clears both flags together, so overwrite never stands alone.
    property p_ovr_implies_held;
        @(posedge clk_in) disable iff (!rst_b_in)
        slot_ovr[0] |-> slot_held[0];
    endproperty
    a_ovr_implies_held: assert property (p_ovr_implies_held)
        else $error("Overwrite flag set while no result is held.");
endmodule

/* File: arh_slot.sv */
// One conversion result slot: value, held flag and overwrite flag.
`timescale 1ns/1ps
`include "arh_consts.svh"
module arh_slot #(
    parameter int RES_W = `ARH_RES_W
) (
    // Clock and reset.
    input  wire logic               clk_in,
    input  wire logic               rst_b_in,
    // Converter side.
    input  wire logic               wr_in,
    input  wire logic [RES_W-1:0]   value_in,
    // Bus side.
    input  wire logic               rd_in,
    // State.
    output logic [RES_W-1:0]        value_out,
    output logic                    held_out,
    output logic                    ovr_out
);
    if (RES_W < 1)
    begin : g_bad_width
        $error("The result must be at least one bit wide.");
    end

    typedef struct packed {
        logic [RES_W-1:0] value;
        logic             held;
        logic             ovr;
    } arh_slot_state_s;

    arh_slot_state_s state_ff;
    arh_slot_state_s nxt_state;

    always_comb
    begin
        nxt_state = state_ff;
        // A write landing in the same cycle as a read wins, so no result is lost.
        if (rd_in)
        begin
            nxt_state.held = 1'b0;
            nxt_state.ovr  = 1'b0;
        end
        if (wr_in)
        begin
            nxt_state.value = value_in;
            nxt_state.held  = 1'b1;
            if (state_ff.held && !rd_in)
            begin
                nxt_state.ovr = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign value_out = state_ff.value;
    assign held_out  = state_ff.held;
    assign ovr_out   = state_ff.ovr;

    property p_held_after_wr;
        @(posedge clk_in) disable iff (!rst_b_in)
        wr_in |=> held_out && value_out == $past(value_in);
    endproperty
    a_held_after_wr: assert property (p_held_after_wr)
        else $error("Held flag or value not updated after write.");

    property p_ovr_set;
        @(posedge clk_in) disable iff (!rst_b_in)
        wr_in && held_out && !rd_in |=> ovr_out;
    endproperty
    a_ovr_set: assert property (p_ovr_set)
        else $error("Overwrite flag not set on unread overwrite.");

    property p_rd_clears;
        @(posedge clk_in) disable iff (!rst_b_in)
        rd_in && !wr_in |=> !held_out && !ovr_out;
    endproperty
    a_rd_clears: assert property (p_rd_clears)
        else $error("Read did not clear the flags.");

    property p_ovr_needs_cause;
        @(posedge clk_in) disable iff (!rst_b_in)
        $rose(ovr_out) |-> $past(wr_in) && $past(held_out);
    endproperty
    a_ovr_needs_cause: assert property (p_ovr_needs_cause)
        else $error("Overwrite flag rose without an overwrite.");

    property p_value_stable;
        @(posedge clk_in) disable iff (!rst_b_in)
        !wr_in |=> $stable(value_out);
    endproperty
    a_value_stable: assert property (p_value_stable)
        else $error("Result value changed without a write.");
endmodule

/* File: test_adc_result_holding_regs.sv */
// Self-checking testbench of the conversion result holding registers.
`timescale 1ns/1ps
`include "arh_consts.svh"
module test_adc_result_holding_regs;
    logic        clk_in     = 1'h0;
    logic        rst_b_in   = 1'h0;
    logic        cyc        = 1'h0;
    logic        stb        = 1'h0;
    logic        we         = 1'h0;
    logic [3:0]  sel        = 4'hf;
    logic [7:0]  adr        = 8'h00;
    logic [31:0] wdat       = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    logic        cwr        = 1'h0;
    logic [1:0]  cslot      = 2'h0;
    logic [9:0]  cval       = 10'h0;
    logic        irq;
    logic [31:0] got;
    logic [9:0]  vals [4]   = '{10'h3ff, 10'h001, 10'h2a5, 10'h15a};
    int          mismatches = 0;
    int          num_checks = 0;
    int          cycles     = 0;

    always #20 clk_in = ~clk_in;

    arh_result_regs i_dut (
        .clk_in        (clk_in),
        .rst_b_in      (rst_b_in),
        .wb_cyc_in     (cyc),
        .wb_stb_in     (stb),
        .wb_we_in      (we),
        .wb_sel_in     (sel),
        .wb_adr_in     (adr),
        .wb_dat_in     (wdat),
        .wb_dat_out    (rdat),
        .wb_ack_out    (ack),
        .conv_wr_in    (cwr),
        .conv_slot_in  (cslot),
        .conv_value_in (cval),
        .irq_out       (irq)
    );

    function automatic logic [31:0] word(input logic [9:0] v, input logic o, input logic h);
        return {16'h0000, v, 4'h0, o, h};
    endfunction

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    // The interrupt is registered, so it is looked at mid-cycle once it has settled.
    task automatic chk_irq(input logic e);
        @(negedge clk_in);
        num_checks++;
        if (irq !== e)
        begin
            mismatches++;
            $display("FAIL irq expected %h seen %h", e, irq);
        end
    endtask

    // The request is held until ack is seen; release lands at that same edge.
    // The wait has no limit of its own; the cycle ceiling ends a hung transfer.
    task automatic wb_io(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        cyc  <= 1'h1;
        stb  <= 1'h1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do
        begin
            @(posedge clk_in);
        end
        while (ack !== 1'h1);
        got = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        we  <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        wb_io(1'h0, a, 32'h0);
        chk_word(nm, e, got);
    endtask

    task automatic conv(input logic [1:0] s, input logic [9:0] v);
        @(posedge clk_in);
        cwr   <= 1'h1;
        cslot <= s;
        cval  <= v;
        @(posedge clk_in);
        cwr <= 1'h0;
    endtask

    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            end_of_test();
        end
    end

    initial
    begin
        repeat (5) @(posedge clk_in);
        rst_b_in <= 1'h1;
        for (int s = 0; s < 4; s++)
        begin
            rd(8'(s * 4), 32'h0, "slot after reset");
        end
        // A write to a slot must not disturb it, so it is tried before the first read of the first result in each slot.
        for (int s = 0; s < 4; s++)
        begin
            conv(2'(s), vals[s]);
            wb_io(1'h1, 8'(s * 4), 32'hffff_ffff);
            rd(8'(s * 4), word(vals[s], 1'h0, 1'h1), "slot new");
            rd(8'(s * 4), word(vals[s], 1'h0, 1'h0), "slot reread");
            conv(2'(s), ~vals[s]);
            conv(2'(s), vals[s]);
            rd(8'(s * 4), word(vals[s], 1'h1, 1'h1), "slot overrun");
            rd(8'(s * 4), word(vals[s], 1'h0, 1'h0), "slot cleared");
        end
        rd(`ARH_OFS_IRQ_STATUS, 32'h0000_00ff, "status");
        chk_irq(1'h0);
        wb_io(1'h1, `ARH_OFS_IRQ_MASK, 32'h0000_0020);
        rd(`ARH_OFS_IRQ_MASK, 32'h0000_0020, "mask");
        chk_irq(1'h1);
        wb_io(1'h1, `ARH_OFS_IRQ_STATUS, 32'h0000_0020);
        chk_irq(1'h0);
        rd(`ARH_OFS_IRQ_STATUS, 32'h0000_00df, "status after clear");
        wb_io(1'h1, `ARH_OFS_IRQ_MASK, 32'h0000_0004);
        // With byte lane 0 off the mask write must be dropped.
        sel <= 4'h0;
        wb_io(1'h1, `ARH_OFS_IRQ_MASK, 32'h0000_0000);
        sel <= 4'hf;
        rd(`ARH_OFS_IRQ_MASK, 32'h0000_0004, "mask lane off");
        chk_irq(1'h1);
        wb_io(1'h1, `ARH_OFS_IRQ_STATUS, 32'h0000_00ff);
        chk_irq(1'h0);
        rd(8'h18, 32'h0, "unmapped");
        end_of_test();
    end
endmodule
